/* include/svnio_pkg.sv */
// constants shared by the supervisor and nv io configuration bank
package svnio_pkg;

  // ****************************************
  // clock and timing
  // ****************************************
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned T_RST_BASE_MS = 125;
  localparam int unsigned RST_BASE_CYC = CLK_HZ / 1000 * T_RST_BASE_MS;
  localparam int unsigned T_EE_WRITE_MS = 10;
  localparam int unsigned EE_WRITE_CYC = CLK_HZ / 1000 * T_EE_WRITE_MS;
  localparam int unsigned RST_CNT_W = 27;
  localparam int unsigned EE_CNT_W = 24;

  // ****************************************
  // bus address and register map
  // ****************************************
  localparam logic [5:0] I2C_ADDR_HI = 6'h28;
  localparam int unsigned NUM_PINS = 4;
  localparam logic [7:0] REG_PULLUP = 8'hf0;
  localparam logic [7:0] REG_RST_DELAY = 8'hf1;
  localparam logic [7:0] REG_PIN_CTRL_0 = 8'hf4;
  localparam logic [7:0] REG_PIN_CTRL_3 = 8'hf7;
  localparam logic [7:0] REG_PIN_STATUS = 8'hf8;
  localparam logic [7:0] REG_CONFIG = 8'hf9;
  localparam logic [7:0] REG_SRAM_FIRST = 8'hfa;
  localparam int unsigned SHADOW_N = 8;
  localparam int unsigned SRAM_N = 6;
  localparam int unsigned IDX_PULLUP = 0;
  localparam int unsigned IDX_RST_DELAY = 1;
  localparam int unsigned IDX_PIN0_CTRL = 7;

  // ****************************************
  // field positions
  // ****************************************
  localparam int unsigned CFG_SEE_BIT = 0;
  localparam int unsigned CFG_SOFT_RESET_REQUEST_BIT = 1;
  localparam int unsigned CFG_RSTST_BIT = 2;
  localparam int unsigned CFG_TRIP_BIT = 3;
  localparam int unsigned CFG_READY_BIT = 4;
  localparam int unsigned CTRL_RELEASE_BIT = 0;
  localparam int unsigned DLY_LO_BIT = 0;
  localparam int unsigned DLY_HI_BIT = 1;

  // ****************************************
  // values after reset and factory contents
  // ****************************************
  localparam logic CFG_SEE_RESET = 1'b0;
  localparam logic [7:0] SH_FACTORY [SHADOW_N] = '{
    8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h01, 8'h01};
  localparam logic [7:0] SRAM_RESET = 8'h00;

endpackage

/* hdl/svnio_sync3.sv */
// three-stage synchroniser, a bit changes once stages two and three agree
module svnio_sync3 #(
  parameter int unsigned W = 1
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_sync
);
  logic [W-1:0] s1_q, s2_q, s3_q, out_q;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else begin
      s1_q <= i_async;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  for (genvar b = 0; b < W; b++) begin : g_bit
    always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) out_q[b] <= 1'b0;
      else if (s2_q[b] == s3_q[b]) out_q[b] <= s3_q[b];
    end
  end

  assign o_sync = out_q;
endmodule

/* hdl/svnio_bit_capture.sv */
// serial clock domain: samples data on each rising clock edge
module svnio_bit_capture (
  input wire logic i_scl_clk,
  input wire logic i_rst,
  input wire logic i_sda,
  output logic o_bit,
  output logic o_toggle
);
  logic bit_q, tog_q;

  // data is held with a toggle so the other domain sees one event per edge
  always_ff @(posedge i_scl_clk or posedge i_rst) begin
    if (i_rst) begin
      bit_q <= 1'b0;
      tog_q <= 1'b0;
    end else begin
      bit_q <= i_sda;
      tog_q <= ~tog_q;
    end
  end

  assign o_bit = bit_q;
  assign o_toggle = tog_q;
endmodule

/* hdl/svnio_bank.sv */
// supervisor and nv io configuration bank behind a two-wire serial port
module svnio_bank #(
  parameter int unsigned P_RST_BASE_CYC = svnio_pkg::RST_BASE_CYC,
  parameter int unsigned P_EE_WRITE_CYC = svnio_pkg::EE_WRITE_CYC
) (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic i_scl_clk,
  input wire logic i_sda,
  output logic o_sda_o,
  output logic o_sda_oe,
  input wire logic i_addr_select_pin,
  input wire logic i_por_ready,
  input wire logic i_supply_above_trip,
  input wire logic i_io_supply_ok,
  input wire logic [svnio_pkg::NUM_PINS-1:0] i_nv_io_pin,
  output logic [svnio_pkg::NUM_PINS-1:0] o_nv_io_pin_o,
  output logic [svnio_pkg::NUM_PINS-1:0] o_nv_io_pin_oe,
  output logic [svnio_pkg::NUM_PINS-1:0] o_nv_io_pullup_en,
  output logic o_rst_n_o,
  output logic o_rst_n_oe
);
  import svnio_pkg::*;

  typedef enum logic [3:0] {
    ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_REG, ST_REG_ACK,
    ST_WDATA, ST_WDATA_ACK, ST_RDATA, ST_RDATA_ACK
  } svnio_i2c_e;

  // ****************************************
  // crossings
  // ****************************************
  logic cap_bit, cap_tog;
  logic [10:0] sync_in, sync_out;
  logic scl_s, sda_s, tog_s, ready_s, trip_s, io_ok_s, asel_s;
  logic [NUM_PINS-1:0] pins_s;

  svnio_bit_capture u_capture (
    .i_scl_clk(i_scl_clk),
    .i_rst(i_rst),
    .i_sda(i_sda),
    .o_bit(cap_bit),
    .o_toggle(cap_tog)
  );

  assign sync_in = {i_nv_io_pin, i_addr_select_pin, i_io_supply_ok,
                    i_supply_above_trip, i_por_ready, cap_tog, i_sda,
                    i_scl_clk};

  svnio_sync3 #(.W(11)) u_sync (
    .i_clk(i_ref_clk),
    .i_rst(i_rst),
    .i_async(sync_in),
    .o_sync(sync_out)
  );

  assign scl_s = sync_out[0];
  assign sda_s = sync_out[1];
  assign tog_s = sync_out[2];
  assign ready_s = sync_out[3];
  assign trip_s = sync_out[4];
  assign io_ok_s = sync_out[5];
  assign asel_s = sync_out[6];
  assign pins_s = sync_out[10:7];

  // ****************************************
  // bus events
  // ****************************************
  logic scl_p_q, sda_p_q, tog_p_q;
  logic start_ev, stop_ev, fall_ev, rise_ev;

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      scl_p_q <= 1'b0;
      sda_p_q <= 1'b0;
      tog_p_q <= 1'b0;
    end else begin
      scl_p_q <= scl_s;
      sda_p_q <= sda_s;
      tog_p_q <= tog_s;
    end
  end

  // oversampling at the reference clock covers fast and standard rates
  assign start_ev = scl_s & scl_p_q & sda_p_q & ~sda_s;
  assign stop_ev = scl_s & scl_p_q & ~sda_p_q & sda_s;
  assign fall_ev = scl_p_q & ~scl_s;
  assign rise_ev = tog_s ^ tog_p_q;

  // ****************************************
  // storage
  // ****************************************
  logic [7:0] sh_q [SHADOW_N];
  logic [7:0] nv_q [SHADOW_N] = SH_FACTORY;
  logic [7:0] sram_q [SRAM_N];
  logic [SHADOW_N-1:0] pend_q;
  logic see_q, soft_reset_request_q, pu_q, busy_q;
  logic [EE_CNT_W-1:0] ee_cnt_q;
  logic rst_act_q, rst_o_q;
  logic [RST_CNT_W-1:0] rst_cnt_q;
  logic wr_stb_q;
  logic [7:0] wr_addr_q, wr_data_q, dly_src;

  function automatic logic [7:0] rd_byte(input logic [7:0] a);
    logic [7:0] r;
    r = 8'h00;
    if (a >= REG_PULLUP && a <= REG_PIN_CTRL_3) begin
      r = sh_q[3'(a - REG_PULLUP)];
    end else if (a == REG_PIN_STATUS) begin
      r = {4'h0, pins_s};
    end else if (a == REG_CONFIG) begin
      r[CFG_SEE_BIT] = see_q;
      r[CFG_SOFT_RESET_REQUEST_BIT] = soft_reset_request_q;
      r[CFG_RSTST_BIT] = rst_act_q;
      r[CFG_TRIP_BIT] = trip_s;
      r[CFG_READY_BIT] = ready_s;
    end else if (a >= REG_SRAM_FIRST) begin
      r = sram_q[3'(a - REG_SRAM_FIRST)];
    end
    return r;
  endfunction

  // ****************************************
  // serial slave state machine
  // ****************************************
  svnio_i2c_e st_q;
  logic [3:0] cnt_q;
  logic [7:0] shift_q, tx_q, ptr_q, rd_now;
  logic rw_q, mack_q, sda_oe_q, sda_o_q;
  always_comb rd_now = rd_byte(ptr_q);

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      st_q <= ST_IDLE;
      cnt_q <= 4'h0;
      shift_q <= 8'h00;
      tx_q <= 8'h00;
      ptr_q <= 8'h00;
      rw_q <= 1'b0;
      mack_q <= 1'b0;
      sda_oe_q <= 1'b0;
      sda_o_q <= 1'b0;
      wr_stb_q <= 1'b0;
      wr_addr_q <= 8'h00;
      wr_data_q <= 8'h00;
    end else begin
      wr_stb_q <= 1'b0;
      sda_o_q <= 1'b0;
      if (start_ev) begin
        st_q <= ST_ADDR;
        cnt_q <= 4'h0;
        sda_oe_q <= 1'b0;
      end else if (stop_ev) begin
        st_q <= ST_IDLE;
        sda_oe_q <= 1'b0;
      end else begin
        unique case (st_q)
          ST_IDLE: begin
            sda_oe_q <= 1'b0;
          end
          ST_ADDR, ST_REG, ST_WDATA: begin
            if (rise_ev && cnt_q != 4'h8) begin
              shift_q <= {shift_q[6:0], cap_bit};
              cnt_q <= cnt_q + 4'h1;
            end else if (fall_ev && cnt_q == 4'h8) begin
              if (st_q == ST_ADDR) begin
                // refuse while programming so the master polls
                if (shift_q[7:1] == {I2C_ADDR_HI, asel_s} && !busy_q) begin
                  sda_oe_q <= 1'b1;
                  rw_q <= shift_q[0];
                  st_q <= ST_ADDR_ACK;
                end else begin
                  st_q <= ST_IDLE;
                end
              end else if (st_q == ST_REG) begin
                ptr_q <= shift_q;
                sda_oe_q <= 1'b1;
                st_q <= ST_REG_ACK;
              end else begin
                wr_stb_q <= 1'b1;
                wr_addr_q <= ptr_q;
                wr_data_q <= shift_q;
                sda_oe_q <= 1'b1;
                st_q <= ST_WDATA_ACK;
              end
            end
          end
          ST_ADDR_ACK, ST_RDATA_ACK: begin
            if (rise_ev) mack_q <= cap_bit;
            if (fall_ev) begin
              if (st_q == ST_ADDR_ACK && !rw_q) begin
                sda_oe_q <= 1'b0;
                cnt_q <= 4'h0;
                st_q <= ST_REG;
              end else if (st_q == ST_RDATA_ACK && mack_q) begin
                sda_oe_q <= 1'b0;
                st_q <= ST_IDLE;
              end else begin
                tx_q <= {rd_now[6:0], 1'b0};
                sda_oe_q <= ~rd_now[7];
                ptr_q <= ptr_q + 8'h01;
                cnt_q <= 4'h1;
                st_q <= ST_RDATA;
              end
            end
          end
          ST_REG_ACK, ST_WDATA_ACK: begin
            if (fall_ev) begin
              sda_oe_q <= 1'b0;
              cnt_q <= 4'h0;
              if (st_q == ST_WDATA_ACK) ptr_q <= ptr_q + 8'h01;
              st_q <= ST_WDATA;
            end
          end
          ST_RDATA: begin
            if (fall_ev) begin
              if (cnt_q == 4'h8) begin
                sda_oe_q <= 1'b0;
                st_q <= ST_RDATA_ACK;
              end else begin
                sda_oe_q <= ~tx_q[7];
                tx_q <= {tx_q[6:0], 1'b0};
                cnt_q <= cnt_q + 4'h1;
              end
            end
          end
        endcase
      end
    end
  end

  // ****************************************
  // register file and shadow memory
  // ****************************************
  logic wr_sh, recall, sw_go, rst_hold, rst_expire;
  logic [2:0] wr_idx;
  logic [1:0] dly_code;
  logic [RST_CNT_W-1:0] dly_cyc;

  assign wr_sh = wr_stb_q && wr_addr_q >= REG_PULLUP
                 && wr_addr_q <= REG_PIN_CTRL_3;
  assign wr_idx = wr_addr_q[2:0];
  assign recall = pu_q & ready_s;
  assign sw_go = wr_stb_q && wr_addr_q == REG_CONFIG
                 && wr_data_q[CFG_SOFT_RESET_REQUEST_BIT];

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      pu_q <= 1'b1;
      see_q <= CFG_SEE_RESET;
      pend_q <= '0;
      for (int i = 0; i < SHADOW_N; i++) sh_q[i] <= SH_FACTORY[i];
      for (int i = 0; i < SRAM_N; i++) sram_q[i] <= SRAM_RESET;
    end else begin
      if (recall) pu_q <= 1'b0;
      if (recall) begin
        for (int i = 0; i < SHADOW_N; i++) sh_q[i] <= nv_q[i];
      end else if (wr_sh) begin
        sh_q[wr_idx] <= wr_data_q;
      end
      if (wr_sh && !see_q) begin
        pend_q[wr_idx] <= 1'b1;
      end else if (stop_ev) begin
        pend_q <= '0;
      end
      if (wr_stb_q && wr_addr_q == REG_CONFIG) begin
        see_q <= wr_data_q[CFG_SEE_BIT];
      end
      if (wr_stb_q && wr_addr_q >= REG_SRAM_FIRST) begin
        sram_q[3'(wr_addr_q - REG_SRAM_FIRST)] <= wr_data_q;
      end
    end
  end

  // nonvolatile copy keeps its contents across reset
  always_ff @(posedge i_ref_clk) begin
    if (stop_ev && !busy_q) begin
      for (int i = 0; i < SHADOW_N; i++) begin
        if (pend_q[i]) nv_q[i] <= sh_q[i];
      end
    end
  end

  // programming interval opens at the stop that ends the write
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      busy_q <= 1'b0;
      ee_cnt_q <= '0;
    end else if (stop_ev && !busy_q && pend_q != '0) begin
      busy_q <= 1'b1;
      ee_cnt_q <= EE_CNT_W'(P_EE_WRITE_CYC - 1);
    end else if (busy_q) begin
      if (ee_cnt_q == '0) busy_q <= 1'b0;
      else ee_cnt_q <= ee_cnt_q - 1'b1;
    end
  end

  // ****************************************
  // cpu supervisor
  // ****************************************
  assign dly_src = pu_q ? nv_q[IDX_RST_DELAY] : sh_q[IDX_RST_DELAY];
  assign dly_code = {dly_src[DLY_HI_BIT], dly_src[DLY_LO_BIT]};
  assign dly_cyc = RST_CNT_W'(P_RST_BASE_CYC) << dly_code;
  assign rst_hold = pu_q | ~ready_s | ~trip_s;
  assign rst_expire = ~rst_hold & ~sw_go & rst_act_q
                      & (rst_cnt_q == '0);

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      soft_reset_request_q <= 1'b0;
    end else if (sw_go) begin
      soft_reset_request_q <= 1'b1;
    end else if (rst_expire) begin
      soft_reset_request_q <= 1'b0;
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      rst_act_q <= 1'b1;
      rst_o_q <= 1'b0;
      rst_cnt_q <= '0;
    end else begin
      rst_o_q <= 1'b0;
      if (rst_hold || sw_go) begin
        rst_cnt_q <= dly_cyc;
        rst_act_q <= 1'b1;
      end else if (rst_cnt_q != '0) begin
        rst_cnt_q <= rst_cnt_q - 1'b1;
        rst_act_q <= 1'b1;
      end else begin
        rst_act_q <= 1'b0;
      end
    end
  end

  // ****************************************
  // nv io pins
  // ****************************************
  logic [NUM_PINS-1:0] pin_oe_q, pin_pu_q, pin_o_q;

  for (genvar p = 0; p < NUM_PINS; p++) begin : g_pin
    always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
        pin_oe_q[p] <= 1'b0;
        pin_pu_q[p] <= 1'b0;
        pin_o_q[p] <= 1'b0;
      end else begin
        pin_o_q[p] <= 1'b0;
        // pins float until the io supply is good and held until it drops
        pin_oe_q[p] <= io_ok_s & ~pu_q
          & ~sh_q[IDX_PIN0_CTRL - p][CTRL_RELEASE_BIT];
        pin_pu_q[p] <= io_ok_s & ~pu_q
          & sh_q[IDX_PULLUP][p];
      end
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign o_sda_o = sda_o_q;
  assign o_sda_oe = sda_oe_q;
  assign o_nv_io_pin_o = pin_o_q;
  assign o_nv_io_pin_oe = pin_oe_q;
  assign o_nv_io_pullup_en = pin_pu_q;
  assign o_rst_n_o = rst_o_q;
  assign o_rst_n_oe = rst_act_q;
endmodule

/* verification/svnio_bank_props.sv */
// assertions on the bank pins
module svnio_bank_props #(
  parameter int unsigned P_RST_BASE_CYC = svnio_pkg::RST_BASE_CYC
) (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic i_scl_clk,
  input wire logic i_por_ready,
  input wire logic i_supply_above_trip,
  input wire logic i_io_supply_ok,
  input wire logic o_sda_o,
  input wire logic o_sda_oe,
  input wire logic [svnio_pkg::NUM_PINS-1:0] o_nv_io_pin_o,
  input wire logic [svnio_pkg::NUM_PINS-1:0] o_nv_io_pin_oe,
  input wire logic [svnio_pkg::NUM_PINS-1:0] o_nv_io_pullup_en,
  input wire logic o_rst_n_o,
  input wire logic o_rst_n_oe
);
  timeunit 1ns;
  timeprecision 100ps;
  import svnio_pkg::*;
  // ****
  // reset hold counter
  // ****
  logic [31:0] act_q;
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      act_q <= '0;
    end else if (!o_rst_n_oe || !i_por_ready || !i_supply_above_trip) begin
      act_q <= '0;
    end else begin
      act_q <= act_q + 32'h1;
    end
  end
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);
  sequence s_por_low;
    !i_por_ready [*6];
  endsequence
  sequence s_trip_low;
    !i_supply_above_trip [*6];
  endsequence
  sequence s_io_low;
    !i_io_supply_ok [*6];
  endsequence
  AST_RST_OD: assert property (o_rst_n_o == 1'b0)
    else $error("reset pin driven high");
  AST_PIN_OD: assert property (o_nv_io_pin_o == '0)
    else $error("io pin driven high");
  AST_SDA_OD: assert property (o_sda_o == 1'b0)
    else $error("data pin driven high");
  AST_POR: assert property (s_por_low |-> o_rst_n_oe)
    else $error("reset released without ready");
  AST_TRIP: assert property (s_trip_low |-> o_rst_n_oe)
    else $error("reset released below trip");
  AST_IO_OFF: assert property (s_io_low |->
    o_nv_io_pin_oe == '0 && o_nv_io_pullup_en == '0)
    else $error("io pins active on low supply");
  AST_RST_MIN: assert property ($fell(o_rst_n_oe) |->
    act_q >= P_RST_BASE_CYC) else $error("reset too short");
  AST_RST_MAX: assert property (act_q <= (P_RST_BASE_CYC << 3) + 64)
    else $error("reset never released");
  AST_SDA_LOW: assert property ($rose(o_sda_oe) |-> !i_scl_clk)
    else $error("data changed with clock high");
endmodule

bind svnio_bank svnio_bank_props #(.P_RST_BASE_CYC(P_RST_BASE_CYC)) u_props (
  .i_ref_clk, .i_rst, .i_scl_clk, .i_por_ready, .i_supply_above_trip,
  .i_io_supply_ok, .o_sda_o, .o_sda_oe, .o_nv_io_pin_o, .o_nv_io_pin_oe,
  .o_nv_io_pullup_en, .o_rst_n_o, .o_rst_n_oe);

/* verification/svnio_i2c_master.sv */
// serial bus master model, link clock runs only within frames
module svnio_i2c_master (
  output logic o_scl,
  output logic o_sda_oe,
  input wire logic i_sda
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam int Q = 6;
  logic tick;
  initial begin
    o_scl = 1'b1;
    o_sda_oe = 1'b0;
    tick = 1'b0;
    #3;
    forever #6 tick = ~tick;
  end
  task automatic hold(input int k);
    repeat (k) @(posedge tick);
  endtask
  task automatic put(input logic b);
    o_sda_oe <= ~b;
    hold(Q);
    o_scl <= 1'b1;
    hold(2 * Q);
    o_scl <= 1'b0;
    hold(Q);
  endtask
  task automatic get(output logic b);
    o_sda_oe <= 1'b0;
    hold(Q);
    o_scl <= 1'b1;
    hold(Q);
    b = i_sda;
    hold(Q);
    o_scl <= 1'b0;
    hold(Q);
  endtask
  task automatic start();
    o_sda_oe <= 1'b0;
    hold(Q);
    o_scl <= 1'b1;
    hold(2 * Q);
    o_sda_oe <= 1'b1;
    hold(2 * Q);
    o_scl <= 1'b0;
    hold(Q);
  endtask
  task automatic stop();
    o_sda_oe <= 1'b1;
    hold(Q);
    o_scl <= 1'b1;
    hold(2 * Q);
    o_sda_oe <= 1'b0;
    hold(4 * Q);
  endtask
  task automatic wbyte(input logic [7:0] v, output logic ack);
    logic b;
    for (int i = 7; i >= 0; i--) put(v[i]);
    get(b);
    ack = ~b;
  endtask
  task automatic wr(input logic [6:0] dev, input logic [7:0] r,
                    input logic [7:0] v, output logic ack);
    logic k;
    start();
    wbyte({dev, 1'b0}, ack);
    if (ack) begin
      wbyte(r, k);
      wbyte(v, k);
    end
    stop();
  endtask
  task automatic rd(input logic [6:0] dev, input logic [7:0] r,
                    output logic [7:0] v, output logic ack);
    logic k;
    v = 8'h00;
    start();
    wbyte({dev, 1'b0}, ack);
    if (ack) begin
      wbyte(r, k);
      start();
      wbyte({dev, 1'b1}, k);
      for (int i = 7; i >= 0; i--) get(v[i]);
      put(1'b1);
    end
    stop();
  endtask
  // address only access, used to poll while busy
  task automatic probe(input logic [6:0] dev, output logic ack);
    start();
    wbyte({dev, 1'b0}, ack);
    stop();
  endtask
endmodule

/* verification/test_svnio_bank.sv */
// bench for the supervisor and io bank
module test_svnio_bank;
  timeunit 1ns;
  timeprecision 100ps;
  import svnio_pkg::*;
  localparam int unsigned BASE = 1000;
  logic i_ref_clk, i_rst, i_scl_clk, i_sda, o_sda_o, o_sda_oe, m_oe;
  logic i_addr_select_pin, i_por_ready, i_supply_above_trip, i_io_supply_ok;
  logic [NUM_PINS-1:0] i_nv_io_pin, o_nv_io_pin_o, o_nv_io_pin_oe;
  logic [NUM_PINS-1:0] o_nv_io_pullup_en, ext;
  logic o_rst_n_o, o_rst_n_oe, a;
  logic [7:0] d;
  int fails, cmp_count, n;
  longint t0;
  assign i_sda = ~(m_oe | o_sda_oe);
  assign i_nv_io_pin = ext & ~o_nv_io_pin_oe;
  svnio_bank #(.P_RST_BASE_CYC(BASE), .P_EE_WRITE_CYC(600)) u_dut (
    .i_ref_clk, .i_rst, .i_scl_clk, .i_sda, .o_sda_o, .o_sda_oe,
    .i_addr_select_pin, .i_por_ready, .i_supply_above_trip,
    .i_io_supply_ok, .i_nv_io_pin, .o_nv_io_pin_o, .o_nv_io_pin_oe,
    .o_nv_io_pullup_en, .o_rst_n_o, .o_rst_n_oe);
  svnio_i2c_master u_master (.o_scl(i_scl_clk), .o_sda_oe(m_oe),
    .i_sda(i_sda));
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic chk1(input logic seen, input logic exp);
    chk({7'h0, seen}, {7'h0, exp});
  endtask
  task automatic end_sim();
    if (fails == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge i_ref_clk);
  endtask
  task automatic wait_fall();
    n = 0;
    while (o_rst_n_oe !== 1'b0) begin
      @(posedge i_ref_clk);
      n++;
      if (n > 9000) begin
        fails++;
        $display("unexpected at %0t: reset hang", $time);
        end_sim();
      end
    end
  endtask
  task automatic t_power_up();
    @(posedge i_ref_clk) i_rst <= 1'b0;
    wait_fall();
    chk1(n >= BASE && n <= BASE + 20, 1'b1);
    chk({o_nv_io_pin_oe, o_nv_io_pullup_en}, 8'h00);
  endtask
  task automatic t_addr();
    u_master.probe(7'h51, a);
    chk1(a, 1'b0);
    @(posedge i_ref_clk) i_addr_select_pin <= 1'b1;
    cyc(8);
    u_master.probe(7'h51, a);
    chk1(a, 1'b1);
    u_master.probe(7'h50, a);
    chk1(a, 1'b0);
    @(posedge i_ref_clk) i_addr_select_pin <= 1'b0;
    cyc(8);
  endtask
  task automatic t_nv();
    u_master.wr(7'h50, 8'hf0, 8'h05, a);
    chk({a, 3'h0, o_nv_io_pullup_en}, 8'h85);
    u_master.probe(7'h50, a);
    chk1(a, 1'b0);
    cyc(700);
    u_master.probe(7'h50, a);
    chk1(a, 1'b1);
  endtask
  task automatic t_shadow();
    u_master.wr(7'h50, 8'hf9, 8'h01, a);
    u_master.wr(7'h50, 8'hf7, 8'h00, a);
    chk({4'h0, o_nv_io_pin_oe}, 8'h01);
    u_master.probe(7'h50, a);
    chk1(a, 1'b1);
    u_master.wr(7'h50, 8'hf4, 8'h00, a);
    chk({4'h0, o_nv_io_pin_oe}, 8'h09);
    u_master.rd(7'h50, 8'hf8, d, a);
    chk(d, 8'h06);
    u_master.wr(7'h50, 8'hf1, 8'h01, a);
  endtask
  task automatic t_soft();
    u_master.wr(7'h50, 8'hf9, 8'h03, a);
    t0 = $time;
    chk1(o_rst_n_oe, 1'b1);
    u_master.rd(7'h50, 8'hf9, d, a);
    chk(d, 8'h1f);
    wait_fall();
    n = int'(($time - t0) / 10);
    chk1(n >= 2 * BASE - 150 && n <= 2 * BASE + 10, 1'b1);
    u_master.rd(7'h50, 8'hf9, d, a);
    chk(d, 8'h19);
    u_master.wr(7'h50, 8'hf1, 8'h03, a);
    u_master.wr(7'h50, 8'hf9, 8'h03, a);
    t0 = $time;
    wait_fall();
    n = int'(($time - t0) / 10);
    chk1(n >= 8 * BASE - 150 && n <= 8 * BASE + 10, 1'b1);
  endtask
  task automatic t_cycle();
    @(posedge i_ref_clk) i_rst <= 1'b1;
    cyc(3);
    @(posedge i_ref_clk) i_rst <= 1'b0;
    wait_fall();
    chk1(n >= BASE && n <= BASE + 20, 1'b1);
    chk({o_nv_io_pin_oe, o_nv_io_pullup_en}, 8'h05);
  endtask
  task automatic t_supply();
    @(posedge i_ref_clk) begin
      i_io_supply_ok <= 1'b0;
      i_supply_above_trip <= 1'b0;
    end
    cyc(8);
    chk({3'h0, o_rst_n_oe, o_nv_io_pullup_en}, 8'h10);
    @(posedge i_ref_clk) i_por_ready <= 1'b0;
    cyc(8);
    chk1(o_rst_n_oe, 1'b1);
    @(posedge i_ref_clk) begin
      i_io_supply_ok <= 1'b1;
      i_supply_above_trip <= 1'b1;
      i_por_ready <= 1'b1;
    end
    wait_fall();
    chk1(n >= BASE, 1'b1);
  endtask
  initial begin
    i_ref_clk = 1'b0;
    forever #5 i_ref_clk = ~i_ref_clk;
  end
  initial begin
    i_rst = 1'b1;
    i_por_ready = 1'b1;
    i_supply_above_trip = 1'b1;
    i_io_supply_ok = 1'b1;
    i_addr_select_pin = 1'b0;
    ext = 4'hf;
    fails = 0;
    cmp_count = 0;
    cyc(3);
    t_power_up();
    t_addr();
    t_nv();
    t_shadow();
    t_soft();
    t_cycle();
    t_supply();
    end_sim();
  end
endmodule
